// ===== hdl/sbc_status_pkg.sv
// Shared constants for the SPI status response block
package sbc_status_pkg;
   // Event sources; index i < 8 is extended status bit i
   localparam int SRC_N       = 9;
   localparam int SRC_REG_LO  = 0;
   localparam int SRC_REG_HI  = 1;
   localparam int SRC_IO_LO   = 2;
   localparam int SRC_IO_HI   = 3;
   localparam int SRC_SW_BUS1 = 4;
   localparam int SRC_SW_BUS2 = 5;
   localparam int SRC_HS_NODE = 6;
   localparam int SRC_CAN_BUS = 7;
   localparam int SRC_SAFE    = 8;
   // Event kinds
   localparam int KIND_N    = 3;
   localparam int KIND_INT  = 0;
   localparam int KIND_WAKE = 1;
   localparam int KIND_RST  = 2;
   // Fixed status bit positions
   localparam int BIT_INT   = 15;
   localparam int BIT_WAKE  = 14;
   localparam int BIT_RST   = 13;
   localparam int BIT_CAN_G = 12;
   localparam int BIT_LIN_G = 11;
   localparam int BIT_IO_G  = 10;
   localparam int BIT_SAFE_G = 9;
   localparam int BIT_REG_G = 8;
   // Command word fields
   localparam int FRAME_BITS = 16;
   localparam int BYTE_BITS  = 8;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam int CLR_SRC_LSB = 8;
   localparam int CLR_SRC_W   = 4;
   // Register map, byte addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_FLAGS  = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_CMD    = 4'hc;
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam logic CTRL_EN_RESET = 1'h1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/spi_frame_if.sv
// Frame carrier between the status core and the SPI shifter
`timescale 1ns/1ps
interface spi_frame_if;
   logic [15:0] status_word;
   logic        resp_en;
   logic [15:0] cmd_word;
   logic        frame_done;
   modport shifter (
      input  status_word,
      input  resp_en,
      output cmd_word,
      output frame_done
   );
   modport core (
      output status_word,
      output resp_en,
      input  cmd_word,
      input  frame_done
   );
endinterface

// ===== hdl/spi_status_response.sv
// Status response top: source flags, summary word and AXI4-Lite registers
// Operation
// R1 - Write command returns fixed plus extended byte
// R2 - Read command returns only fixed byte
// R3 - Bit 15 set while interrupt flags pending
// R4 - Bit 14 set while wake flags pending
// R5 - Bit 13 set while reset flags pending
// R6 - Bit 12 marks CAN local or bus source
// R7 - Bit 11 marks either LIN channel source
// R8 - Bit 10 marks I/O wake pin source
// R9 - Bit 9 marks fail-safe source
// R10 - Bit 8 marks regulator or voltage monitor
// R11 - Extended bit 7 marks CAN bus cause
// R12 - Extended bit 6 marks CAN local cause
// R13 - Extended bit 5 marks second LIN channel
// R14 - Extended bit 4 marks first LIN channel
// R15 - Extended bit 2 marks low I/O page
// R16 - Extended bit 3 marks high I/O page
// R17 - Extended bit 1 marks high regulator page
// R18 - Extended bit 0 marks low regulator page
// R19 - SPI flag read clears latched source flags
// R20 - Response shifted MSB first, fixed byte high
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module spi_status_response (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // AXI4-Lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // AXI4-Lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read address
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // AXI4-Lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Event pulses from device logic, one bit per source
   input  wire logic [8:0]  evt_int,
   input  wire logic [8:0]  evt_wake,
   input  wire logic [8:0]  evt_reset,
   // SPI pins
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe_n
);
   localparam int N = sbc_status_pkg::SRC_N;

   spi_frame_if fr ();

   logic [N-1:0]  evt      [sbc_status_pkg::KIND_N];
   logic [N-1:0]  flag_q   [sbc_status_pkg::KIND_N];
   logic [N-1:0]  clr_mask;
   logic [N-1:0]  src_pend;
   logic [2:0]    kind_pend;
   logic [4:0]    grp_pend;
   logic [15:0]   next_status;
   logic [15:0]   last_cmd;
   logic          resp_en;
   logic          clr_all;
   logic          spi_clear;
   logic [3:0]    aw_addr;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          do_write;
   logic [2:0]    wr_sel;

   // Map a byte address onto a register index, 4 when unmapped
   function automatic logic [2:0] reg_sel(input logic [3:0] a);
      case (a)
         sbc_status_pkg::ADDR_CTRL:   reg_sel = 3'h0;
         sbc_status_pkg::ADDR_FLAGS:  reg_sel = 3'h1;
         sbc_status_pkg::ADDR_STATUS: reg_sel = 3'h2;
         sbc_status_pkg::ADDR_CMD:    reg_sel = 3'h3;
         default:                     reg_sel = 3'h4;
      endcase
   endfunction

   // One-hot source mask from the clear field of a read command
   function automatic logic [N-1:0] src_decode(input logic [15:0] c);
      logic [3:0] idx;
      idx = c[sbc_status_pkg::CLR_SRC_LSB +: sbc_status_pkg::CLR_SRC_W];
      src_decode = '0;
      if (idx < 4'(N)) begin
         src_decode[idx] = 1'b1;
      end
   endfunction

   assign evt[sbc_status_pkg::KIND_INT]  = evt_int;
   assign evt[sbc_status_pkg::KIND_WAKE] = evt_wake;
   assign evt[sbc_status_pkg::KIND_RST]  = evt_reset;

   // A completed read frame addresses one source for clearing
   assign spi_clear = fr.frame_done
      && fr.cmd_word[15:14] != sbc_status_pkg::CMD_WRITE;

   always_comb begin
      clr_mask = '0;
      if (clr_all) begin
         clr_mask = '1;
      end else if (spi_clear) begin
         clr_mask = src_decode(fr.cmd_word); // R19
      end
   end

   // Sticky flags per kind; a new event beats a clear in the same cycle
   generate
      for (genvar k = 0; k < sbc_status_pkg::KIND_N; k++) begin : g_kind
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flag_q[k] <= '0;
            end else begin
               flag_q[k] <= (flag_q[k] & ~clr_mask) | evt[k]; // R19
            end
         end
         assign kind_pend[k] = |flag_q[k];
      end
   endgenerate

   // Any kind pending from each source
   assign src_pend = flag_q[0] | flag_q[1] | flag_q[2];

   // Group summaries of the fixed byte
   assign grp_pend[4] = src_pend[sbc_status_pkg::SRC_CAN_BUS]
                      | src_pend[sbc_status_pkg::SRC_HS_NODE]; // R6
   assign grp_pend[3] = src_pend[sbc_status_pkg::SRC_SW_BUS2]
                      | src_pend[sbc_status_pkg::SRC_SW_BUS1]; // R7
   assign grp_pend[2] = src_pend[sbc_status_pkg::SRC_IO_HI]
                      | src_pend[sbc_status_pkg::SRC_IO_LO]; // R8
   assign grp_pend[1] = src_pend[sbc_status_pkg::SRC_SAFE]; // R9
   assign grp_pend[0] = src_pend[sbc_status_pkg::SRC_REG_HI]
                      | src_pend[sbc_status_pkg::SRC_REG_LO]; // R10

   // Assemble the 16 bit response word
   always_comb begin
      next_status = 16'h0000;
      next_status[sbc_status_pkg::BIT_INT] =
         kind_pend[sbc_status_pkg::KIND_INT]; // R3
      next_status[sbc_status_pkg::BIT_WAKE] =
         kind_pend[sbc_status_pkg::KIND_WAKE]; // R4
      next_status[sbc_status_pkg::BIT_RST] =
         kind_pend[sbc_status_pkg::KIND_RST]; // R5
      next_status[sbc_status_pkg::BIT_CAN_G:sbc_status_pkg::BIT_REG_G] = grp_pend;
      // Extended byte: source index equals bit position
      next_status[7:0] = src_pend[7:0]; // R11 R12 R13 R14 R15 R16 R17 R18
   end

   // Registered so the shifter samples a clean word at select
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fr.status_word <= 16'h0000;
      end else begin
         fr.status_word <= next_status; // R20
      end
   end

   assign fr.resp_en = resp_en;

   spi_status_shifter u_shift (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .sclk      (sclk),
      .cs_n      (cs_n),
      .mosi      (mosi),
      .miso      (miso),
      .miso_oe_n (miso_oe_n),
      .fr        (fr)
   );

   // Keep the last full command for software inspection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_cmd <= 16'h0000;
      end else if (fr.frame_done) begin
         last_cmd <= fr.cmd_word;
      end
   end

   // Write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_addr <= 4'h0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_addr <= awaddr;
      end else if (do_write) begin
         awready <= 1'b1;
      end
   end

   // Write data channel, taken independently of the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         wready <= 1'b1;
      end
   end

   assign do_write = !awready && !wready && !bvalid;
   assign wr_sel   = reg_sel(aw_addr);

   // Write response; only the control register is writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= sbc_status_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= (wr_sel == 3'h0) ? sbc_status_pkg::RESP_OKAY
                                    : sbc_status_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Control register; clear-all is a one-cycle strobe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_en <= sbc_status_pkg::CTRL_EN_RESET;
         clr_all <= 1'b0;
      end else begin
         clr_all <= 1'b0;
         if (do_write && wr_sel == 3'h0 && w_strb[0]) begin
            resp_en <= w_data[sbc_status_pkg::CTRL_EN_BIT];
            clr_all <= w_data[sbc_status_pkg::CTRL_CLR_BIT];
         end
      end
   end

   // Read channel; data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= sbc_status_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= sbc_status_pkg::RESP_OKAY;
         case (reg_sel(araddr))
            3'h0: rdata <= {31'h0, resp_en};
            3'h1: rdata <= {5'h00, flag_q[2], flag_q[1], flag_q[0]};
            3'h2: rdata <= {16'h0000, fr.status_word};
            3'h3: rdata <= {16'h0000, last_cmd};
            default: begin
               rdata <= 32'h00000000;
               rresp <= sbc_status_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [N-1:0] evt_any;
   assign evt_any = evt_int | evt_wake | evt_reset;

   AST_INT_SUM: assert property (|evt_int |=> ##1 fr.status_word[15]) // R3
      else $error("interrupt summary not set");
   AST_WAKE_SUM: assert property (|evt_wake |=> ##1 fr.status_word[14]) // R4
      else $error("wake summary not set");
   AST_RST_SUM: assert property (|evt_reset |=> ##1 fr.status_word[13]) // R5
      else $error("reset summary not set");
   AST_CAN_GRP: assert property (|evt_any[7:6] |=> ##1 fr.status_word[12]) // R6
      else $error("CAN group not set");
   AST_LIN_GRP: assert property (|evt_any[5:4] |=> ##1 fr.status_word[11]) // R7
      else $error("LIN group not set");
   AST_IO_GRP: assert property (|evt_any[3:2] |=> ##1 fr.status_word[10]) // R8
      else $error("I/O group not set");
   AST_SAFE_GRP: assert property (evt_any[8] |=> ##1 fr.status_word[9]) // R9
      else $error("safe group not set");
   AST_REG_GRP: assert property (|evt_any[1:0] |=> ##1 fr.status_word[8]) // R10
      else $error("regulator group not set");
   AST_EXT_SRC: assert property (##2 ((fr.status_word[7:0] & $past(evt_any[7:0], 2))
      == $past(evt_any[7:0], 2))) // R11
      else $error("extended source bit missing");
   AST_EMPTY_CLEAR: assert property (kind_pend == 3'h0 |=> fr.status_word == 16'h0000) // R19
      else $error("status not clear with nothing pending");

   // Write answer: one edge after both halves are taken
   sequence s_write_taken;
      !awready && !wready && !bvalid;
   endsequence
   sequence s_write_answer;
      bvalid && awready && wready;
   endsequence
   AST_WRITE_ANSWER: assert property (s_write_taken |=> s_write_answer)
      else $error("write response not raised after both handshakes");

   // Answers stand until the master takes them; a dropped one loses a transfer
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   AST_R_HOLD: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped before rready");
   AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data not offered after the address");

   // Enable bit follows a control write with its low byte strobed
   AST_CTRL_EN: assert property (do_write && wr_sel == 3'h0 && w_strb[0]
      |=> resp_en == $past(w_data[sbc_status_pkg::CTRL_EN_BIT]))
      else $error("enable bit not written");

   // A read frame drops its source unless an event lands in the same cycle
   AST_SPI_CLEAR: assert property (spi_clear && (evt_any & clr_mask) == '0 // R19
      |=> (src_pend & $past(clr_mask)) == '0)
      else $error("read frame left its source pending");
   // Clear-all empties every flag when no event competes
   AST_CLEAR_ALL: assert property (clr_all && evt_any == '0 |=> src_pend == '0)
      else $error("clear-all left a flag set");
   // Set wins over any clear in the same cycle
   AST_SET_WINS: assert property (|evt_any // R19
      |=> (src_pend & $past(evt_any)) == $past(evt_any))
      else $error("new event lost to a clear");
endmodule

// ===== hdl/spi_status_shifter.sv
// SPI slave shifter: samples the pins, shifts status out and command in
`timescale 1ns/1ps
module spi_status_shifter (
   // Clock and reset
   input  wire logic    aclk,
   input  wire logic    aresetn,
   // SPI pins
   input  wire logic    sclk,
   input  wire logic    cs_n,
   input  wire logic    mosi,
   output logic         miso,
   output logic         miso_oe_n,
   // Core side
   spi_frame_if.shifter fr
);
   logic        sclk_s1, sclk_s2, sclk_d;
   logic        cs_s1, cs_s2, cs_d;
   logic        mosi_s1, mosi_s2;
   logic [15:0] tx_shift;
   logic [15:0] rx_shift;
   logic [4:0]  bit_cnt;
   logic [1:0]  cmd_type;
   logic        cs_fall, cs_rise, sclk_rise, sclk_fall;
   logic        next_miso;

   // Two stage synchronisers, then one edge history flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         cs_d    <= 1'b1;
         mosi_s1 <= 1'b0;
         mosi_s2 <= 1'b0;
      end else begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         cs_s1   <= cs_n;
         cs_s2   <= cs_s1;
         cs_d    <= cs_s2;
         mosi_s1 <= mosi;
         mosi_s2 <= mosi_s1;
      end
   end

   assign cs_fall   = cs_d & ~cs_s2;
   assign cs_rise   = ~cs_d & cs_s2;
   assign sclk_rise = ~sclk_d & sclk_s2 & ~cs_s2;
   assign sclk_fall = sclk_d & ~sclk_s2 & ~cs_s2;

   // Status is frozen at select so a frame never shows a half update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_shift <= 16'h0000;
         rx_shift <= 16'h0000;
         bit_cnt  <= 5'h00;
         cmd_type <= 2'h0;
      end else if (cs_fall) begin
         tx_shift <= fr.status_word; // R20
         rx_shift <= 16'h0000;
         bit_cnt  <= 5'h00;
      end else if (sclk_rise) begin
         rx_shift <= {rx_shift[14:0], mosi_s2};
         if (bit_cnt == 5'h01) begin
            cmd_type <= {rx_shift[0], mosi_s2};
         end
         // Count one past a full frame so an overlong frame is refused too
         if (bit_cnt != 5'(sbc_status_pkg::FRAME_BITS + 1)) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end else if (sclk_fall) begin
         tx_shift <= {tx_shift[14:0], 1'b0}; // R20
      end
   end

   // Reads return only the fixed byte, the second byte stays low
   always_comb begin
      next_miso = tx_shift[15];
      if (bit_cnt >= 5'(sbc_status_pkg::BYTE_BITS)
          && cmd_type != sbc_status_pkg::CMD_WRITE) begin
         next_miso = 1'b0; // R2
      end
   end

   // Pin drive; released whenever select is high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miso      <= 1'b0;
         miso_oe_n <= 1'b1;
      end else begin
         miso      <= cs_s2 ? 1'b0 : next_miso; // R1
         miso_oe_n <= cs_s2 | ~fr.resp_en;
      end
   end

   // Only complete 16 bit frames are handed to the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fr.cmd_word   <= 16'h0000;
         fr.frame_done <= 1'b0;
      end else begin
         fr.frame_done <= cs_rise
            && bit_cnt == 5'(sbc_status_pkg::FRAME_BITS);
         if (cs_rise) begin
            fr.cmd_word <= rx_shift;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_select;
      cs_fall;
   endsequence
   sequence s_second_byte(logic wr);
      !cs_s2 && bit_cnt >= 5'h08 && bit_cnt <= 5'h0f
      && ((cmd_type == sbc_status_pkg::CMD_WRITE) == wr);
   endsequence

   AST_LOAD_MSB: assert property (s_select |=> tx_shift == $past(fr.status_word)) // R20
      else $error("status not loaded at select");
   AST_WRITE_EXT: assert property (s_second_byte(1'b1) |=> miso == $past(tx_shift[15])) // R1
      else $error("extended byte missing on write");
   AST_READ_ONE: assert property (s_second_byte(1'b0) |=> !miso) // R2
      else $error("read returned a second byte");
   AST_IDLE_OFF: assert property (cs_s2 |=> miso_oe_n && !miso)
      else $error("miso driven while deselected");
endmodule

// ===== verif/spi_host_model.sv
// Host-side SPI master model running mode 0 frames against the block
`timescale 1ns/1ps
module spi_host_model #(
   parameter int HALF_NS = 160
) (
   // SPI pins driven by the host
   output logic     sclk,
   output logic     cs_n,
   output logic     mosi,
   // SPI pins driven by the device
   input wire logic miso,
   input wire logic miso_oe_n
);
   // Idle: clock parked low, device deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One frame of nbits clocks; also counts bits seen with the driver enabled
   task automatic run_frame(input logic [15:0] cmd, input int nbits,
                            output logic [15:0] resp, output int oe_cnt);
      resp = 16'h0000;
      oe_cnt = 0;
      // Offset keeps link edges off the system clock edges
      #13;
      cs_n = 1'b0;
      mosi = cmd[15];
      #(2 * HALF_NS);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         // A released line reads as the inverse of its last level
         resp = {resp[14:0], miso_oe_n ? ~miso : miso};
         oe_cnt += (miso_oe_n === 1'b0) ? 1 : 0;
         #(HALF_NS);
         sclk = 1'b0;
         if (i < 15) begin
            mosi = cmd[14 - i];
         end
         #(HALF_NS);
      end
      cs_n = 1'b1;
      // Released data line shows the inverse, so no stale level passes as data
      mosi = ~mosi;
      #(3 * HALF_NS);
   endtask
endmodule

// ===== verif/tb_spi_status_response.sv
// Self-checking bench: registers, event flags and SPI status frames
`timescale 1ns/1ps
module tb_spi_status_response;
   // Design pins
   logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic            arvalid, arready, rvalid, rready, sclk, cs_n, mosi, miso, miso_oe_n;
   logic [3:0]      awaddr, wstrb, araddr;
   logic [31:0]     wdata, rdata;
   logic [1:0]      bresp, rresp;
   logic [8:0]      evt_int, evt_wake, evt_reset;
   // Reference flags: index 0 interrupt, 1 wake, 2 reset
   logic [2:0][8:0] exp_f;
   logic [15:0]     last_cmd;
   int              num_errors;
   int              total_checks;

   spi_status_response i_spi_status_response (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .evt_int, .evt_wake, .evt_reset, .sclk, .cs_n, .mosi, .miso, .miso_oe_n
   );
   spi_host_model i_spi_host_model (.sclk, .cs_n, .mosi, .miso, .miso_oe_n);

   // System clock
   initial aclk = 1'b0;
   always #20 aclk = ~aclk;

   // Expected status word from the reference flags
   function automatic logic [15:0] exp_word();
      logic [8:0] any;
      any = exp_f[0] | exp_f[1] | exp_f[2];
      return {|exp_f[0], |exp_f[1], |exp_f[2],
              |any[7:6], |any[5:4], |any[3:2], any[8], |any[1:0],
              any[7:0]};
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // A handshake that never comes ends the run
   task automatic stall();
      num_errors++;
      $display("unexpected handshake: expected answer seen none");
      give_verdict();
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (n == 64) stall();
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 64) stall();
   endtask

   task automatic reg_check(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check("rdata", ed, d);
      check("rresp", {30'h0, er}, {30'h0, r});
   endtask

   // One-cycle event pulses, mirrored into the reference flags
   task automatic fire(input logic [8:0] vi, input logic [8:0] vw, input logic [8:0] vr);
      @(posedge aclk);
      evt_int <= vi;
      evt_wake <= vw;
      evt_reset <= vr;
      @(posedge aclk);
      evt_int <= 9'h000;
      evt_wake <= 9'h000;
      evt_reset <= 9'h000;
      exp_f = exp_f | {vr, vw, vi};
   endtask

   // Full or malformed frame, then the status, flag and command registers
   task automatic frame(input logic [15:0] cmd, input int nbits, input logic en);
      logic [15:0] resp;
      logic [15:0] ew;
      int          oe_cnt;
      ew = exp_word();
      if (cmd[15:14] != sbc_status_pkg::CMD_WRITE) begin
         ew[7:0] = 8'h00;
      end
      i_spi_host_model.run_frame(cmd, nbits, resp, oe_cnt);
      if (en && nbits == 16) begin
         check("miso word", {16'h0, ew}, {16'h0, resp});
      end
      check("oe bits", en ? 32'(nbits) : 32'h0, 32'(oe_cnt));
      // Only an exact 16-bit read frame clears its source
      if (nbits == 16) begin
         last_cmd = cmd;
         if (cmd[15:14] != sbc_status_pkg::CMD_WRITE && cmd[11:8] < 4'h9) begin
            for (int k = 0; k < 3; k++) exp_f[k][cmd[11:8]] = 1'b0;
         end
      end
      repeat (8) @(posedge aclk);
      reg_check(sbc_status_pkg::ADDR_STATUS, {16'h0, exp_word()}, 2'h0);
      reg_check(sbc_status_pkg::ADDR_FLAGS, {5'h00, exp_f}, 2'h0);
      reg_check(sbc_status_pkg::ADDR_CMD, {16'h0, last_cmd}, 2'h0);
   endtask

   initial begin
      logic [1:0] r;
      logic [8:0] v;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, evt_int, evt_wake, evt_reset} = '0;
      exp_f = '0;
      last_cmd = 16'h0000;
      num_errors = 0;
      total_checks = 0;
      void'($urandom(32'h3f0a80c7));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      // Reset values, a read-only write and an unmapped read
      reg_check(sbc_status_pkg::ADDR_CTRL, 32'h1, 2'h0);
      reg_check(sbc_status_pkg::ADDR_FLAGS, 32'h0, 2'h0);
      reg_check(4'h6, 32'h0, sbc_status_pkg::RESP_SLVERR);
      axi_write(sbc_status_pkg::ADDR_FLAGS, 32'hffffffff, r);
      check("bresp", {30'h0, sbc_status_pkg::RESP_SLVERR}, {30'h0, r});
      reg_check(sbc_status_pkg::ADDR_CMD, 32'h0, 2'h0);
      // Every source and kind alone: write frame shows it, read frame clears it
      for (int k = 0; k < 3; k++) begin
         for (int s = 0; s < 9; s++) begin
            v = 9'h001 << s;
            fire(k == 0 ? v : 9'h0, k == 1 ? v : 9'h0, k == 2 ? v : 9'h0);
            frame({2'b01, 14'($urandom)}, 16, 1'b1);
            frame({s[0] ? 2'b11 : 2'b00, 2'($urandom), 4'(s), 8'($urandom)}, 16, 1'b1);
         end
      end
      // Random mixes, with short and long frames that must be ignored
      for (int n = 0; n < 24; n++) begin
         fire(9'($urandom), 9'($urandom), 9'($urandom));
         frame(16'($urandom), n % 12 == 5 ? 15 : (n % 12 == 11 ? 17 : 16), 1'b1);
      end
      // Clear-all strobe, then a frame with the response disabled
      fire(9'h1ff, 9'h1ff, 9'h1ff);
      axi_write(sbc_status_pkg::ADDR_CTRL, 32'h3, r);
      check("bresp", 32'h0, {30'h0, r});
      exp_f = '0;
      reg_check(sbc_status_pkg::ADDR_CTRL, 32'h1, 2'h0);
      axi_write(sbc_status_pkg::ADDR_CTRL, 32'h0, r);
      frame(16'h4000, 16, 1'b0);
      axi_write(sbc_status_pkg::ADDR_CTRL, 32'h1, r);
      frame(16'hc000, 16, 1'b1);
      give_verdict();
   end
endmodule
